// ===== verilog/ls_sample_cfg.svh
`ifndef LS_SAMPLE_CFG_SVH
`define LS_SAMPLE_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_INFO_LO     8'h00
`define OFF_INFO_HI     8'h04
`define OFF_FABRIC_LO   8'h08
`define OFF_FABRIC_HI   8'h0C
`define OFF_VADDR_LO    8'h10
`define OFF_VADDR_HI    8'h14
`define OFF_PADDR_LO    8'h18
`define OFF_PADDR_HI    8'h1C
`define OFF_CTRL        8'h20
`define OFF_IRQ_STAT    8'h24
`define OFF_IRQ_MASK    8'h28

// ----------------------------------------
// fields
// ----------------------------------------
`define CTRL_ENABLE_BIT 0
`define IRQ_SAMPLE_BIT  0
`define IRQ_OVF_BIT     1
`define IRQ_W           2
`define SRC_NONE        3'h0
`define SRC_L3          3'h1
`define SRC_CACHE       3'h2
`define SRC_DRAM        3'h3
`define SRC_IO          3'h7
`define LAT_W           16
`define LAT_MAX         16'hFFFF
`define INFO_FLAGS_LSB  0
`define INFO_LAT_LSB    32
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== verilog/ls_sample_pkg.sv
package ls_sample_pkg;

  // per-op outcome flags from the load/store unit
  typedef struct packed {
    logic load_flag;
    logic store_flag;
    logic first_dtlb_miss;
    logic second_dtlb_miss;
    logic first_dtlb_hit_2m;
    logic first_dtlb_hit_1g;
    logic second_dtlb_hit_2m;
    logic dcache_miss_flag;
    logic misaligned_access;
    logic load_bank_conflict;
    logic store_bank_conflict;
    logic store_forwarded;
    logic store_forward_cancelled;
    logic uncacheable_access;
    logic write_combining_access;
    logic locked_access;
    logic miss_buffer_hit;
    logic virt_addr_valid;
    logic phys_addr_valid;
  } ls_flags_t;

  // fabric report for a load that missed both caches
  typedef struct packed {
    logic       fabric_cache_state;
    logic       fabric_remote_dest;
    logic [2:0] fabric_data_source;
  } fabric_info_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MISS = 2'b01,
    ST_DONE = 2'b10
  } cap_state_t;

endpackage : ls_sample_pkg

// ===== verilog/load_store_sample_capture.sv
`include "ls_sample_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module load_store_sample_capture
  import ls_sample_pkg::*;
#(
  parameter int VA_W = 48,
  parameter int PA_W = 48
) (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // load/store unit
  input  wire logic              op_sampled,
  input  wire ls_flags_t         op_flags,
  input  wire logic [VA_W-1:0]   op_virt_addr,
  input  wire logic [PA_W-1:0]   op_phys_addr,
  input  wire logic              l2_miss,
  input  wire logic              dcache_write,
  // request fabric
  input  wire logic              fabric_valid,
  input  wire fabric_info_t      fabric_info,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // interrupt
  output logic                   irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] word_of(input logic [63:0] v, input logic hi);
    word_of = hi ? v[63:32] : v[31:0];
  endfunction : word_of

  function automatic logic timed_load(input ls_flags_t f);
    timed_load = f.load_flag && f.dcache_miss_flag;
  endfunction : timed_load

  // ----------------------------------------
  // capture state
  // ----------------------------------------
  cap_state_t          st_q, st_d;
  ls_flags_t           pend_q, pend_d, flags_q, flags_d;
  logic [VA_W-1:0]     pva_q, pva_d, va_q, va_d;
  logic [PA_W-1:0]     ppa_q, ppa_d, pa_q, pa_d;
  logic [`LAT_W-1:0]   cnt_q, cnt_d, lat_q, lat_d;
  logic                pl2_q, pl2_d;
  fabric_info_t        fab_q, fab_d;
  logic                done_ev, ovf_ev;
  logic                enable_q, enable_d;

  always_comb begin
    st_d    = st_q;
    pend_d  = pend_q;
    pva_d   = pva_q;
    ppa_d   = ppa_q;
    cnt_d   = cnt_q;
    pl2_d   = pl2_q;
    flags_d = flags_q;
    va_d    = va_q;
    pa_d    = pa_q;
    lat_d   = lat_q;
    fab_d   = fab_q;
    done_ev = 1'b0;
    ovf_ev  = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // ops arriving while disabled are dropped
        if (enable_q && op_sampled) begin
          pend_d = op_flags;
          pva_d  = op_virt_addr;
          ppa_d  = op_phys_addr;
          pl2_d  = l2_miss;
          cnt_d  = '0;
          if (timed_load(op_flags))
            st_d = ST_MISS;
          else
            st_d = ST_DONE;
        end
      end
      ST_MISS: begin
        // count until data written
        // saturate, so a very long miss never reads short
        if (cnt_q != `LAT_MAX)
          cnt_d = cnt_q + `LAT_W'(1);
        if (l2_miss)
          pl2_d = 1'b1;
        if (dcache_write)
          st_d = ST_DONE;
      end
      ST_DONE: begin
        done_ev = 1'b1;
        st_d    = ST_IDLE;
        flags_d = pend_q;
        va_d    = pend_q.virt_addr_valid ? pva_q : '0;
        pa_d    = pend_q.phys_addr_valid ? ppa_q : '0;
        lat_d   = timed_load(pend_q) ? cnt_q : '0;
        fab_d   = '0;
        // fabric only for loads missing both levels
        if (timed_load(pend_q) && pl2_q && fabric_valid) begin
          if (fabric_info.fabric_data_source != `SRC_NONE)
            fab_d = fabric_info;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // disabling aborts a capture in flight; a finished one still lands
    if (!enable_q && st_q != ST_DONE)
      st_d = ST_IDLE;
    // a second op while busy is lost, so software is told
    if (op_sampled && st_q != ST_IDLE)
      ovf_ev = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q    <= ST_IDLE;
      pend_q  <= '0;
      pva_q   <= '0;
      ppa_q   <= '0;
      cnt_q   <= '0;
      pl2_q   <= 1'b0;
      flags_q <= '0;
      va_q    <= '0;
      pa_q    <= '0;
      lat_q   <= '0;
      fab_q   <= '0;
    end else if (clk_en) begin
      st_q    <= st_d;
      pend_q  <= pend_d;
      pva_q   <= pva_d;
      ppa_q   <= ppa_d;
      cnt_q   <= cnt_d;
      pl2_q   <= pl2_d;
      flags_q <= flags_d;
      va_q    <= va_d;
      pa_q    <= pa_d;
      lat_q   <= lat_d;
      fab_q   <= fab_d;
    end
  end

  // ----------------------------------------
  // register images
  // ----------------------------------------
  logic [63:0] info_img, fab_img, va_img, pa_img;
  always_comb begin
    info_img = 64'h0;
    info_img[`INFO_FLAGS_LSB +: $bits(ls_flags_t)] = flags_q;
    // latency alone in the upper word, one read returns it whole
    info_img[`INFO_LAT_LSB +: `LAT_W] = lat_q;
  end
  assign fab_img  = {59'h0, fab_q};
  // address bits above the operand width read as zero
  assign va_img   = 64'(va_q);
  assign pa_img   = 64'(pa_q);

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0]        awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic              wstrb0_q, wstrb0_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [`IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic              do_write;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq           = |(stat_q & mask_q);

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_write  = 1'b0;
    // address and data may come in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (aw_held_q && w_held_q) begin
      do_write  = 1'b1;
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_OKAY;
      case (awaddr_q)
        `OFF_CTRL, `OFF_IRQ_MASK, `OFF_IRQ_STAT: bresp_d = `RESP_OKAY;
        `OFF_INFO_LO, `OFF_INFO_HI, `OFF_FABRIC_LO, `OFF_FABRIC_HI,
        `OFF_VADDR_LO, `OFF_VADDR_HI, `OFF_PADDR_LO, `OFF_PADDR_HI: begin
          bresp_d = `RESP_SLVERR;
        end
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready && !do_write)
      bvalid_d = 1'b0;
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    // halves are not latched together; read both between samples
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      case (s_axi_araddr)
        `OFF_INFO_LO:   rdata_d = word_of(info_img, 1'b0);
        `OFF_INFO_HI:   rdata_d = word_of(info_img, 1'b1);
        `OFF_FABRIC_LO: rdata_d = word_of(fab_img, 1'b0);
        `OFF_FABRIC_HI: rdata_d = word_of(fab_img, 1'b1);
        `OFF_VADDR_LO:  rdata_d = word_of(va_img, 1'b0);
        `OFF_VADDR_HI:  rdata_d = word_of(va_img, 1'b1);
        `OFF_PADDR_LO:  rdata_d = word_of(pa_img, 1'b0);
        `OFF_PADDR_HI:  rdata_d = word_of(pa_img, 1'b1);
        `OFF_CTRL:      rdata_d = {31'h0, enable_q};
        `OFF_IRQ_STAT:  rdata_d = {30'h0, stat_q};
        `OFF_IRQ_MASK:  rdata_d = {30'h0, mask_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end else if (clk_en) begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= 2'h0;
      rdata_q  <= 32'h0;
    end else if (clk_en) begin
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // ----------------------------------------
  // control and status
  // ----------------------------------------
  always_comb begin
    enable_d = enable_q;
    mask_d   = mask_q;
    stat_d   = stat_q;
    // only byte lane 0 carries control bits
    if (do_write && wstrb0_q) begin
      case (awaddr_q)
        `OFF_CTRL:     enable_d = wdata_q[`CTRL_ENABLE_BIT];
        `OFF_IRQ_MASK: mask_d   = wdata_q[`IRQ_W-1:0];
        `OFF_IRQ_STAT: stat_d   = stat_q & ~wdata_q[`IRQ_W-1:0];
        default:       enable_d = enable_q;
      endcase
    end
    // set wins over a clear in the same cycle, no event is lost
    if (done_ev)
      stat_d[`IRQ_SAMPLE_BIT] = 1'b1;
    if (ovf_ev)
      stat_d[`IRQ_OVF_BIT] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q <= 1'b0;
      mask_q   <= '0;
      stat_q   <= '0;
    end else if (clk_en) begin
      enable_q <= enable_d;
      mask_q   <= mask_d;
      stat_q   <= stat_d;
    end
  end

endmodule : load_store_sample_capture

`default_nettype wire

// ===== test/ls_sample_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ls_sample_chk (
  // clock, reset
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ----
  // bus timing
  // ----
  // frozen cycles end every check, a stall is not a slip
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  ro_write_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && s_axi_awaddr < 8'h20
    |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("sample register write not refused");
endmodule : ls_sample_chk
bind load_store_sample_capture ls_sample_chk i_chk (.*);
`default_nettype wire

// ===== test/lsu_fabric_model.sv
`timescale 1ns/1ns
`default_nettype none
module lsu_fabric_model
  import ls_sample_pkg::*;
(
  // core clock
  input  wire logic   clk,
  // load/store unit
  output logic        op_sampled,
  output ls_flags_t   op_flags,
  output logic [47:0] op_virt_addr,
  output logic [47:0] op_phys_addr,
  output logic        l2_miss,
  output logic        dcache_write,
  // fabric
  output logic        fabric_valid,
  output fabric_info_t fabric_info
);
  initial begin
    {op_sampled, dcache_write, fabric_valid, l2_miss} = 4'h0;
    op_flags = '0;
    {op_virt_addr, op_phys_addr} = '0;
    fabric_info = '0;
  end
  // ----
  // one sampled op
  // ----
  // flag, address and fabric info lines are inverted once released so stale values never match; l2_miss stays held
  task automatic issue(input ls_flags_t f, input logic [47:0] va, pa,
                       input logic l2, fv, input fabric_info_t fi, input int k);
    @(posedge clk);
    op_sampled <= 1'b1;
    op_flags <= f;
    op_virt_addr <= va;
    op_phys_addr <= pa;
    l2_miss <= l2;
    @(posedge clk);
    op_sampled <= 1'b0;
    op_flags <= ~f;
    op_virt_addr <= ~va;
    op_phys_addr <= ~pa;
    if (f.load_flag && f.dcache_miss_flag) begin
      repeat (k - 1) @(posedge clk);
      dcache_write <= 1'b1;
      @(posedge clk);
      dcache_write <= 1'b0;
    end
    fabric_valid <= fv;
    fabric_info <= fi;
    @(posedge clk);
    fabric_valid <= 1'b0;
    fabric_info <= ~fi;
  endtask : issue
endmodule : lsu_fabric_model
`default_nettype wire

// ===== test/tb_load_store_sample_capture.sv
`include "ls_sample_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_load_store_sample_capture
  import ls_sample_pkg::*;
;
  logic         clk = 0;
  logic         sys_rst = 1;
  logic         clk_en = 1;
  logic         op_sampled, l2_miss, dcache_write, fabric_valid, irq;
  ls_flags_t    op_flags;
  fabric_info_t fabric_info;
  logic [47:0]  op_virt_addr, op_phys_addr;
  logic [7:0]   awaddr = 0, araddr = 0;
  logic [31:0]  wdata = 0, rdata;
  logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  int           miscompares = 0, cmp_count = 0, cyc = 0;
  always #25 clk = ~clk;
  load_store_sample_capture i_dut (.clk_en(clk_en), .s_axi_wstrb(4'hF),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .*);
  lsu_fabric_model i_lsu (.*);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(bresp, er);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk(rdata, e);
    chk(rresp, er);
  endtask : rdc
  task automatic complete_run();
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    ls_flags_t    f;
    fabric_info_t fi;
    logic [47:0]  va, pa;
    logic         l2, fv, m;
    int           k;
    logic [2:0]   src [5];
    src = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    void'($urandom(32'h7FA13FE1));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(`OFF_CTRL, 32'h0, `RESP_OKAY);
    rdc(8'h30, 32'h0, `RESP_SLVERR);
    wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    wr(`OFF_IRQ_MASK, 32'h1, `RESP_OKAY);
    for (int i = 0; i < 12; i++) begin
      f = ls_flags_t'(19'($urandom));
      va = 48'({$urandom, $urandom});
      pa = 48'({$urandom, $urandom});
      fi = fabric_info_t'({2'($urandom), src[i % 5]});
      l2 = 1'($urandom);
      fv = 1'($urandom);
      k = $urandom_range(20, 1);
      if (i < 5) {f.load_flag, f.dcache_miss_flag, l2, fv} = 4'hF;
      if (i == 5) {f.load_flag, f.store_flag, f.dcache_miss_flag} = 3'h3;
      if (i == 6) {f.virt_addr_valid, f.phys_addr_valid} = 2'h1;
      m = f.load_flag && f.dcache_miss_flag;
      i_lsu.issue(f, va, pa, l2, fv, fi, k);
      repeat (40) if (irq !== 1'b1) @(posedge clk);
      chk(irq, 32'h1);
      rdc(`OFF_INFO_LO, {13'h0, f}, `RESP_OKAY);
      rdc(`OFF_INFO_HI, m ? k : 0, `RESP_OKAY);
      rdc(`OFF_FABRIC_LO, (m && l2 && fv && |fi[2:0]) ? {27'h0, fi} : 0, `RESP_OKAY);
      rdc(`OFF_VADDR_LO, f.virt_addr_valid ? va[31:0] : 0, `RESP_OKAY);
      rdc(`OFF_VADDR_HI, f.virt_addr_valid ? va[47:32] : 0, `RESP_OKAY);
      rdc(`OFF_PADDR_LO, f.phys_addr_valid ? pa[31:0] : 0, `RESP_OKAY);
      rdc(`OFF_PADDR_HI, f.phys_addr_valid ? pa[47:32] : 0, `RESP_OKAY);
      wr(`OFF_INFO_LO, 32'hFFFFFFFF, `RESP_SLVERR);
      rdc(`OFF_INFO_LO, {13'h0, f}, `RESP_OKAY);
      wr(`OFF_IRQ_STAT, 32'h1, `RESP_OKAY);
      chk(irq, 32'h0);
    end
    wr(`OFF_IRQ_MASK, 32'h0, `RESP_OKAY);
    i_lsu.issue(f, va, pa, l2, fv, fi, 3);
    repeat (20) @(posedge clk);
    chk(irq, 32'h0);
    rdc(`OFF_IRQ_STAT, 32'h1, `RESP_OKAY);
    wr(`OFF_IRQ_MASK, 32'h1, `RESP_OKAY);
    chk(irq, 32'h1);
    wr(`OFF_IRQ_STAT, 32'h1, `RESP_OKAY);
    @(posedge clk);
    clk_en <= 1'b0;
    i_lsu.issue(f, va, pa, l2, fv, fi, 3);
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    rdc(`OFF_IRQ_STAT, 32'h0, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
    i_lsu.issue(f, va, pa, l2, fv, fi, 3);
    repeat (20) @(posedge clk);
    rdc(`OFF_IRQ_STAT, 32'h0, `RESP_OKAY);
    complete_run();
  end
endmodule : tb_load_store_sample_capture
`default_nettype wire
